// >>> testbench/hrmacs_regs_props.sv
/*
  Concurrent checks on the ports of the receiver register bank.
  Assumes one clock, CLK_SYS, and the asynchronous active-low reset RSTN.
*/
`timescale 1ns/1ps
module hrmacs_regs_props (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RSTN,
  // Register port
  input wire logic [hrmacs_pkg::ADDR_W-1:0] REG_ADDR,
  input wire logic [hrmacs_pkg::DATA_W-1:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [hrmacs_pkg::DATA_W-1:0] REG_RDATA,
  // Link and FIFO events
  input wire logic GCP_VALID,
  input wire logic GCP_SET_AVMUTE,
  input wire logic GCP_CLEAR_AVMUTE,
  input wire logic AFIFO_UNDERFLOW,
  input wire logic AFIFO_OVERFLOW,
  // Outputs
  input wire logic AFIFO_RESET,
  input wire logic AV_MUTE,
  input wire logic VIDEO_MUTE,
  input wire logic AUDIO_MUTE,
  input wire logic MCLK_PLL_EN,
  input wire logic [3:0] MCLK_DIVISOR,
  input wire logic [hrmacs_pkg::FS_RATIO_W-1:0] MCLK_FS_RATIO,
  input wire logic DDC_PULLUP_EN,
  input wire logic DDC_SDA_OE,
  input wire logic DDC_SCL_OE,
  input wire logic CLK_TERM_OFF
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);
  // Shadows of the mute and link control registers, so checks can see what software set.
  logic [7:0] mute_ctl_ff;
  logic [7:0] line_ctl_ff;
  wire wr57 = REG_WR && REG_ADDR == 8'h57;
  wire wr58 = REG_WR && REG_ADDR == 8'h58;
  wire wr59 = REG_WR && REG_ADDR == 8'h59;
  wire fault_en = (AFIFO_UNDERFLOW && line_ctl_ff[2]) || (AFIFO_OVERFLOW && line_ctl_ff[1]);
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      mute_ctl_ff <= 8'h00;
      line_ctl_ff <= 8'h00;
    end else begin
      if (wr57) mute_ctl_ff <= REG_WDATA;
      if (wr59) line_ctl_ff <= REG_WDATA;
    end
  end
  sequence s_wr58; wr58; endsequence
  sequence s_wr59; wr59; endsequence
  sequence s_gcp_set;
    GCP_VALID && GCP_SET_AVMUTE && !GCP_CLEAR_AVMUTE && !mute_ctl_ff[7] ##1 !mute_ctl_ff[7];
  endsequence
  property p_rd_idle; !$past(REG_RD) |-> REG_RDATA == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero outside read slot");
  property p_pll; s_wr58 |-> ##2 MCLK_PLL_EN == $past(REG_WDATA[7], 2); endproperty
  a_pll: assert property (p_pll) else $error("pll enable wrong");
  property p_div; s_wr58 |-> ##2 MCLK_DIVISOR == {1'b0, $past(REG_WDATA[6:4], 2)} + 4'h1; endproperty
  a_div: assert property (p_div) else $error("divisor wrong");
  property p_fs;
    s_wr58 |-> ##2 MCLK_FS_RATIO == ({8'h00, $past(REG_WDATA[2:0], 2)} + 11'h001) << 7;
  endproperty
  a_fs: assert property (p_fs) else $error("fs ratio wrong");
  property p_pu; s_wr59 |-> ##2 DDC_PULLUP_EN == !$past(REG_WDATA[6], 2); endproperty
  a_pu: assert property (p_pu) else $error("pull-up enable wrong");
  property p_oe; s_wr59 |-> ##2 DDC_SDA_OE == !$past(REG_WDATA[0], 2) && DDC_SCL_OE == DDC_SDA_OE; endproperty
  a_oe: assert property (p_oe) else $error("line enables wrong");
  property p_term; wr59 && REG_WDATA[5] |-> ##2 CLK_TERM_OFF == $past(REG_WDATA[4], 2); endproperty
  a_term: assert property (p_term) else $error("manual termination wrong");
  property p_fifo; AFIFO_RESET == $past(fault_en); endproperty
  a_fifo: assert property (p_fifo) else $error("fifo reset wrong");
  property p_ovr; $past(mute_ctl_ff[7]) |-> AV_MUTE == $past(mute_ctl_ff[6]); endproperty
  a_ovr: assert property (p_ovr) else $error("override mute wrong");
  property p_vid; VIDEO_MUTE == (AV_MUTE && !$past(mute_ctl_ff[3])); endproperty
  a_vid: assert property (p_vid) else $error("video mute wrong");
  property p_aud; AUDIO_MUTE == (AV_MUTE && !$past(mute_ctl_ff[2])); endproperty
  a_aud: assert property (p_aud) else $error("audio mute wrong");
  property p_gcp; s_gcp_set |=> AV_MUTE; endproperty
  a_gcp: assert property (p_gcp) else $error("link mute not followed");
endmodule : hrmacs_regs_props

bind hrmacs_regs hrmacs_regs_props u_props (
  .CLK_SYS(CLK_SYS), .RSTN(RSTN), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
  .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .GCP_VALID(GCP_VALID),
  .GCP_SET_AVMUTE(GCP_SET_AVMUTE), .GCP_CLEAR_AVMUTE(GCP_CLEAR_AVMUTE),
  .AFIFO_UNDERFLOW(AFIFO_UNDERFLOW), .AFIFO_OVERFLOW(AFIFO_OVERFLOW), .AFIFO_RESET(AFIFO_RESET),
  .AV_MUTE(AV_MUTE), .VIDEO_MUTE(VIDEO_MUTE), .AUDIO_MUTE(AUDIO_MUTE), .MCLK_PLL_EN(MCLK_PLL_EN),
  .MCLK_DIVISOR(MCLK_DIVISOR), .MCLK_FS_RATIO(MCLK_FS_RATIO), .DDC_PULLUP_EN(DDC_PULLUP_EN),
  .DDC_SDA_OE(DDC_SDA_OE), .DDC_SCL_OE(DDC_SCL_OE), .CLK_TERM_OFF(CLK_TERM_OFF)
);

// >>> testbench/hrmacs_regs_tb.sv
/*
  Self-checking bench for the receiver register bank.
  Assumes the fixed latencies of the register port and control outputs.
*/
`timescale 1ns/1ps
module hrmacs_regs_tb;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0, rd = 1'b0, hdmi = 1'b1, det = 1'b1, lost = 1'b0, uf = 1'b0, of = 1'b0;
  logic [7:0] rdata;
  logic gv, gs, gc, pv, av, cv, fr, avm, vm, am, pll, pu, sda, scl, toff;
  logic [2:0] pt;
  logic [19:0] cts, n;
  logic [31:0] csd;
  logic [3:0] wl, dv;
  logic [10:0] fs;
  int mismatches = 0;
  int checks = 0;

  hrmacs_src src (.clk(clk), .gcp_valid(gv), .gcp_set(gs), .gcp_clr(gc), .pkt_valid(pv), .pkt_type(pt),
    .acr_valid(av), .acr_cts(cts), .acr_n(n), .cs_valid(cv), .cs_data(csd), .cs_len(wl));
  hrmacs_regs dut (.CLK_SYS(clk), .RSTN(rstn), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr),
    .REG_RD(rd), .REG_RDATA(rdata), .GCP_VALID(gv), .GCP_SET_AVMUTE(gs), .GCP_CLEAR_AVMUTE(gc),
    .PKT_VALID(pv), .PKT_TYPE(pt), .CLK_LOST(lost), .ACR_VALID(av), .ACR_CTS(cts), .ACR_N(n),
    .CS_VALID(cv), .CS_STATUS(csd[31:24]), .CS_CATEGORY(csd[23:16]), .CS_CH_SRC(csd[15:8]),
    .CS_ACC_RATE(csd[7:0]), .CS_WORD_LEN(wl), .HDMI_MODE(hdmi), .TMDS_CLK_DET(det),
    .AFIFO_UNDERFLOW(uf), .AFIFO_OVERFLOW(of), .AFIFO_RESET(fr), .AV_MUTE(avm), .VIDEO_MUTE(vm),
    .AUDIO_MUTE(am), .MCLK_PLL_EN(pll), .MCLK_DIVISOR(dv), .MCLK_FS_RATIO(fs), .DDC_PULLUP_EN(pu),
    .DDC_SDA_OE(sda), .DDC_SCL_OE(scl), .CLK_TERM_OFF(toff));

  initial begin
    forever #25 clk = ~clk;
  end

  task automatic end_sim();
    if (mismatches == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input logic [10:0] seen, input logic [10:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : tick
  task automatic wrr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    {wr, addr, wdata} <= {1'b1, a, d};
    @(posedge clk);
    wr <= 1'b0;
  endtask : wrr
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    {rd, addr} <= {1'b1, a};
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk({3'b000, rdata}, {3'b000, e});
  endtask : rdc
  task automatic flt(input logic u, input logic o, input logic e);
    @(posedge clk);
    {uf, of} <= {u, o};
    @(posedge clk);
    {uf, of} <= 2'b00;
    #1;
    chk(fr, e);
    tick(1);
    chk(fr, 1'b0);
  endtask : flt

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    end_sim();
  end

  initial begin
    tick(7);
    chk(dv, 4'h1);
    chk(fs, 11'h080);
    chk({pu, sda, scl, toff, fr, avm}, 6'h3C);
    @(posedge clk);
    rstn <= 1'b1;
    rdc(8'h56, 8'h0F);
    rdc(8'h57, 8'h00);
    rdc(8'h58, 8'h00);
    rdc(8'h59, 8'h00);
    rdc(8'h5A, 8'h00);
    rdc(8'h30, 8'h00);
    chk(toff, 1'b0);
    wrr(8'h56, 8'h00);
    rdc(8'h56, 8'h00);
    wrr(8'h56, 8'h0F);
    rdc(8'h56, 8'h0F);
    wrr(8'h5A, 8'hFF);
    rdc(8'h5A, 8'h00);
    wrr(8'h57, 8'hFF);
    rdc(8'h57, 8'hCC);
    wrr(8'h59, 8'hFF);
    rdc(8'h59, 8'h77);
    chk({pu, sda, scl, toff}, 4'h1);
    wrr(8'h59, 8'h20);
    tick(1);
    chk({pu, sda, scl, toff}, 4'hE);
    wrr(8'h59, 8'h00);
    det <= 1'b0;
    tick(5);
    chk(toff, 1'b1);
    det <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      wrr(8'h58, {1'b1, 3'(i), 1'b0, 3'(i)});
      tick(1);
      chk(dv, 11'(i + 1));
      chk(fs, 11'((i + 1) * 128));
      chk(pll, 1'b1);
    end
    wrr(8'h58, 8'h00);
    tick(1);
    chk(pll, 1'b0);
    wrr(8'h57, 8'h00);
    src.gcp(1'b1, 1'b0);
    tick(1);
    chk({avm, vm, am}, 3'h7);
    wrr(8'h57, 8'h0C);
    tick(1);
    chk({avm, vm, am}, 3'h4);
    wrr(8'h57, 8'h80);
    tick(1);
    chk(avm, 1'b0);
    src.gcp(1'b0, 1'b1);
    src.gcp(1'b1, 1'b1);
    wrr(8'h57, 8'hC0);
    tick(1);
    chk(avm, 1'b1);
    wrr(8'h57, 8'h00);
    tick(1);
    chk(avm, 1'b0);
    flt(1'b1, 1'b1, 1'b0);
    wrr(8'h59, 8'h04);
    flt(1'b1, 1'b0, 1'b1);
    flt(1'b0, 1'b1, 1'b0);
    wrr(8'h59, 8'h02);
    flt(1'b0, 1'b1, 1'b1);
    for (int t = 0; t < 8; t++) begin
      src.pkt(3'(t));
      rdc(8'h5A, 8'((2 << (t > 6 ? 6 : t)) - 1));
    end
    @(posedge clk);
    lost <= 1'b1;
    tick(4);
    lost <= 1'b0;
    rdc(8'h5A, 8'h00);
    src.acr(20'hABCDE, 20'h12345);
    rdc(8'h7B, 8'hAB);
    rdc(8'h7C, 8'hCD);
    rdc(8'h7D, 8'hE1);
    rdc(8'h7E, 8'h23);
    rdc(8'h7F, 8'h45);
    wrr(8'h58, 8'h08);
    src.acr(20'h54321, 20'h0F0F0);
    rdc(8'h7B, 8'hAB);
    rdc(8'h7F, 8'h45);
    wrr(8'h58, 8'h00);
    src.acr(20'h54321, 20'h0F0F0);
    rdc(8'h7B, 8'h54);
    rdc(8'h7F, 8'hF0);
    src.cs(32'h065A21FF, 4'hD);
    rdc(8'h5E, 8'h06);
    rdc(8'h5F, 8'h5A);
    rdc(8'h60, 8'h21);
    rdc(8'h61, 8'h3F);
    rdc(8'h62, 8'h0D);
    src.cs(32'h08000000, 4'h0);
    rdc(8'h5E, 8'h08);
    rdc(8'h5B, 8'h08);
    hdmi <= 1'b0;
    rdc(8'h5B, 8'h00);
    end_sim();
  end
endmodule : hrmacs_regs_tb

// >>> testbench/hrmacs_src.sv
/*
  Behavioural source side of the link: sends packet events as one-cycle pulses.
  Assumes the caller runs its tasks one after another from a single process.
*/
`timescale 1ns/1ps
module hrmacs_src (
  // Clock
  input wire logic clk,
  // Packet events
  output logic gcp_valid,
  output logic gcp_set,
  output logic gcp_clr,
  output logic pkt_valid,
  output logic [2:0] pkt_type,
  output logic acr_valid,
  output logic [19:0] acr_cts,
  output logic [19:0] acr_n,
  output logic cs_valid,
  output logic [31:0] cs_data,
  output logic [3:0] cs_len
);
  initial begin
    {gcp_valid, gcp_set, gcp_clr, pkt_valid, acr_valid, cs_valid} = 6'h00;
    {pkt_type, acr_cts, acr_n, cs_data, cs_len} = '0;
  end
  // Qualifiers are inverted once valid drops, so a stale value never looks right.
  task automatic gcp(input logic s, input logic c);
    @(posedge clk);
    {gcp_valid, gcp_set, gcp_clr} <= {1'b1, s, c};
    @(posedge clk);
    {gcp_valid, gcp_set, gcp_clr} <= {1'b0, !s, !c};
  endtask : gcp
  task automatic pkt(input logic [2:0] t);
    @(posedge clk);
    {pkt_valid, pkt_type} <= {1'b1, t};
    @(posedge clk);
    {pkt_valid, pkt_type} <= {1'b0, ~t};
  endtask : pkt
  task automatic acr(input logic [19:0] c, input logic [19:0] n);
    @(posedge clk);
    {acr_valid, acr_cts, acr_n} <= {1'b1, c, n};
    @(posedge clk);
    {acr_valid, acr_cts, acr_n} <= {1'b0, ~c, ~n};
  endtask : acr
  task automatic cs(input logic [31:0] d, input logic [3:0] l);
    @(posedge clk);
    {cs_valid, cs_data, cs_len} <= {1'b1, d, l};
    @(posedge clk);
    {cs_valid, cs_data, cs_len} <= {1'b0, ~d, ~l};
  endtask : cs
endmodule : hrmacs_src

// >>> verilog/hrmacs_acr_store.sv
/*
  Holds the cycle time stamp and N value of the last accepted clock
  regeneration packet. Assumes the packet strobe is on CLK_SYS.
*/
`timescale 1ns/1ps
module hrmacs_acr_store #(
  parameter int W = hrmacs_pkg::ACR_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Packet input
  input wire logic acr_valid,
  input wire logic [W-1:0] acr_cts,
  input wire logic [W-1:0] acr_n,
  input wire logic update_block,
  // Stored values
  output logic [W-1:0] cts_ff,
  output logic [W-1:0] n_ff
);
  initial begin
    if (W != hrmacs_pkg::ACR_W) begin
      $error("hrmacs_acr_store: W must match the register layout.");
    end
  end

  wire take = acr_valid && !update_block;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cts_ff <= '0;
      n_ff <= '0;
    end else if (take) begin
      cts_ff <= acr_cts;
      n_ff <= acr_n;
    end
  end
endmodule : hrmacs_acr_store

// >>> verilog/hrmacs_pkg.sv
/*
  Shared constants of the receiver mute, audio clock and status register bank:
  register offsets, field positions, reset values and widths.
  Assumes an 8-bit register port with byte-wide registers at byte offsets.
*/
package hrmacs_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int PKT_NUM = 7;
  localparam int ACR_W = 20;
  localparam int FS_RATIO_W = 11;

  // Register offsets.
  localparam logic [7:0] OFS_TEST_CFG_B = 8'h56;
  localparam logic [7:0] OFS_AV_MUTE_CTRL = 8'h57;
  localparam logic [7:0] OFS_MCLK_SETUP = 8'h58;
  localparam logic [7:0] OFS_LINK_FIFO_CTRL = 8'h59;
  localparam logic [7:0] OFS_PKT_SEEN = 8'h5A;
  localparam logic [7:0] OFS_LINK_MODE = 8'h5B;
  localparam logic [7:0] OFS_AUDIO_STATUS = 8'h5E;
  localparam logic [7:0] OFS_AUDIO_CATEGORY = 8'h5F;
  localparam logic [7:0] OFS_AUDIO_CH_SRC = 8'h60;
  localparam logic [7:0] OFS_AUDIO_ACC_RATE = 8'h61;
  localparam logic [7:0] OFS_AUDIO_WORD_LEN = 8'h62;
  localparam logic [7:0] OFS_CTS_HI = 8'h7B;
  localparam logic [7:0] OFS_CTS_MID = 8'h7C;
  localparam logic [7:0] OFS_CTS_LO_N_HI = 8'h7D;
  localparam logic [7:0] OFS_N_MID = 8'h7E;
  localparam logic [7:0] OFS_N_LO = 8'h7F;

  // Reset values.
  localparam logic [7:0] RST_TEST_CFG_B = 8'h0F;
  localparam logic [7:0] RST_AV_MUTE_CTRL = 8'h00;
  localparam logic [7:0] RST_MCLK_SETUP = 8'h00;
  localparam logic [7:0] RST_LINK_FIFO_CTRL = 8'h00;
  localparam logic [7:0] RST_ZERO = 8'h00;

  // Mute control fields.
  localparam int BIT_MUTE_OVERRIDE = 7;
  localparam int BIT_MUTE_SW_VALUE = 6;
  localparam int BIT_VIDEO_MUTE_DIS = 3;
  localparam int BIT_AUDIO_MUTE_DIS = 2;
  localparam logic [7:0] MASK_AV_MUTE_CTRL = 8'hCC;

  // Master clock setup fields.
  localparam int BIT_MCLK_PLL_EN = 7;
  localparam int POS_MCLK_DIV_LO = 4;
  localparam int MCLK_DIV_W = 3;
  localparam int BIT_ACR_UPDATE_BLOCK = 3;
  localparam int POS_FS_MULT_LO = 0;
  localparam int FS_MULT_W = 3;
  localparam int FS_UNIT = 128;

  // Link line and FIFO control fields.
  localparam int BIT_DDC_PULLUP_DIS = 6;
  localparam int BIT_TERM_OVERRIDE = 5;
  localparam int BIT_TERM_MANUAL_OFF = 4;
  localparam int BIT_FIFO_UF_AUTORESET = 2;
  localparam int BIT_FIFO_OF_AUTORESET = 1;
  localparam int BIT_DDC_TRISTATE = 0;
  localparam logic [7:0] MASK_LINK_FIFO_CTRL = 8'h77;

  // Link mode status field.
  localparam int BIT_HDMI_MODE = 3;
endpackage : hrmacs_pkg

// >>> verilog/hrmacs_pkt_flags.sv
/*
  Sticky packet-seen flags, one per packet type code below NUM.
  Assumes packet strobes and the loss-of-clock level are already on CLK_SYS.
*/
`timescale 1ns/1ps
module hrmacs_pkt_flags #(
  parameter int NUM = hrmacs_pkg::PKT_NUM
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Packet events
  input wire logic pkt_valid,
  input wire logic [2:0] pkt_type,
  input wire logic clk_lost,
  // Flags
  output logic [NUM-1:0] seen_ff
);
  initial begin
    if (NUM < 1 || NUM > 8) begin
      $error("hrmacs_pkt_flags: NUM must be 1 to 8.");
    end
  end

  genvar i;
  generate
    for (i = 0; i < NUM; i = i + 1) begin : g_flag
      wire hit = pkt_valid && (pkt_type == 3'(i));
      // A packet arriving together with the clear still marks the flag.
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          seen_ff[i] <= 1'b0;
        end else if (hit) begin
          seen_ff[i] <= 1'b1;
        end else if (clk_lost) begin
          seen_ff[i] <= 1'b0;
        end
      end
    end
  endgenerate
endmodule : hrmacs_pkt_flags

// >>> verilog/hrmacs_regs.sv
/*
  Register bank of an HDMI/DVI receiver: AV mute control, audio master clock
  setup, display data channel and termination control, audio FIFO auto-reset,
  packet-seen status, stored clock regeneration values and audio channel status.
  Assumes link events arrive as CLK_SYS pulses from the receiver core, while the
  clock-detect and clock-loss levels come from pins and are synchronised here.
*/
`timescale 1ns/1ps
module hrmacs_regs (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RSTN,
  // Register port
  input wire logic [hrmacs_pkg::ADDR_W-1:0] REG_ADDR,
  input wire logic [hrmacs_pkg::DATA_W-1:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [hrmacs_pkg::DATA_W-1:0] REG_RDATA,
  // Link mute indication
  input wire logic GCP_VALID,
  input wire logic GCP_SET_AVMUTE,
  input wire logic GCP_CLEAR_AVMUTE,
  // Packet detection
  input wire logic PKT_VALID,
  input wire logic [2:0] PKT_TYPE,
  input wire logic CLK_LOST,
  // Clock regeneration packets
  input wire logic ACR_VALID,
  input wire logic [hrmacs_pkg::ACR_W-1:0] ACR_CTS,
  input wire logic [hrmacs_pkg::ACR_W-1:0] ACR_N,
  // Audio channel status
  input wire logic CS_VALID,
  input wire logic [7:0] CS_STATUS,
  input wire logic [7:0] CS_CATEGORY,
  input wire logic [7:0] CS_CH_SRC,
  input wire logic [7:0] CS_ACC_RATE,
  input wire logic [3:0] CS_WORD_LEN,
  // Link state
  input wire logic HDMI_MODE,
  input wire logic TMDS_CLK_DET,
  // Audio FIFO
  input wire logic AFIFO_UNDERFLOW,
  input wire logic AFIFO_OVERFLOW,
  output logic AFIFO_RESET,
  // Mute outputs
  output logic AV_MUTE,
  output logic VIDEO_MUTE,
  output logic AUDIO_MUTE,
  // Master clock setup
  output logic MCLK_PLL_EN,
  output logic [3:0] MCLK_DIVISOR,
  output logic [hrmacs_pkg::FS_RATIO_W-1:0] MCLK_FS_RATIO,
  // Link line control
  output logic DDC_PULLUP_EN,
  output logic DDC_SDA_OE,
  output logic DDC_SCL_OE,
  output logic CLK_TERM_OFF
);
  // The ratio port must hold the largest multiple, and the packet flags must
  // leave the top bit of their byte free for the zero fill.
  initial begin
    if ((1 << hrmacs_pkg::FS_MULT_W) * hrmacs_pkg::FS_UNIT >= (1 << hrmacs_pkg::FS_RATIO_W)) begin
      $error("hrmacs_regs: FS_RATIO_W is too narrow for the largest ratio.");
    end
    if (hrmacs_pkg::PKT_NUM >= hrmacs_pkg::DATA_W) begin
      $error("hrmacs_regs: PKT_NUM must be below the register width.");
    end
  end

  // Pin synchronisers.
  logic clk_lost_meta_ff;
  logic clk_lost_ff;
  logic clk_det_meta_ff;
  logic clk_det_ff;

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      clk_lost_meta_ff <= 1'b0;
      clk_lost_ff <= 1'b0;
      clk_det_meta_ff <= 1'b0;
      clk_det_ff <= 1'b0;
    end else begin
      clk_lost_meta_ff <= CLK_LOST;
      clk_lost_ff <= clk_lost_meta_ff;
      clk_det_meta_ff <= TMDS_CLK_DET;
      clk_det_ff <= clk_det_meta_ff;
    end
  end

  // Address decode.
  wire wr_test = REG_WR && (REG_ADDR == hrmacs_pkg::OFS_TEST_CFG_B);
  wire wr_mute = REG_WR && (REG_ADDR == hrmacs_pkg::OFS_AV_MUTE_CTRL);
  wire wr_mclk = REG_WR && (REG_ADDR == hrmacs_pkg::OFS_MCLK_SETUP);
  wire wr_link = REG_WR && (REG_ADDR == hrmacs_pkg::OFS_LINK_FIFO_CTRL);

  // Software registers. Write masks keep unimplemented bits of the mute and link
  // registers at zero, so their read-back shows only the fields that have an effect.
  logic [7:0] test_config_b_ff;
  logic [7:0] av_mute_control_ff;
  logic [7:0] audio_master_clock_setup_ff;
  logic [7:0] link_line_and_fifo_control_ff;

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      test_config_b_ff <= hrmacs_pkg::RST_TEST_CFG_B;
      av_mute_control_ff <= hrmacs_pkg::RST_AV_MUTE_CTRL;
      audio_master_clock_setup_ff <= hrmacs_pkg::RST_MCLK_SETUP;
      link_line_and_fifo_control_ff <= hrmacs_pkg::RST_LINK_FIFO_CTRL;
    end else begin
      if (wr_test) begin
        test_config_b_ff <= REG_WDATA;
      end
      if (wr_mute) begin
        av_mute_control_ff <= REG_WDATA & hrmacs_pkg::MASK_AV_MUTE_CTRL;
      end
      if (wr_mclk) begin
        audio_master_clock_setup_ff <= REG_WDATA;
      end
      if (wr_link) begin
        link_line_and_fifo_control_ff <= REG_WDATA & hrmacs_pkg::MASK_LINK_FIFO_CTRL;
      end
    end
  end

  // Field extraction.
  wire mute_override = av_mute_control_ff[hrmacs_pkg::BIT_MUTE_OVERRIDE];
  wire mute_sw_value = av_mute_control_ff[hrmacs_pkg::BIT_MUTE_SW_VALUE];
  wire video_mute_dis = av_mute_control_ff[hrmacs_pkg::BIT_VIDEO_MUTE_DIS];
  wire audio_mute_dis = av_mute_control_ff[hrmacs_pkg::BIT_AUDIO_MUTE_DIS];
  wire pll_en = audio_master_clock_setup_ff[hrmacs_pkg::BIT_MCLK_PLL_EN];
  wire [2:0] mclk_div =
    audio_master_clock_setup_ff[hrmacs_pkg::POS_MCLK_DIV_LO +: hrmacs_pkg::MCLK_DIV_W];
  wire acr_update_block = audio_master_clock_setup_ff[hrmacs_pkg::BIT_ACR_UPDATE_BLOCK];
  wire [2:0] master_clk_fs_multiple =
    audio_master_clock_setup_ff[hrmacs_pkg::POS_FS_MULT_LO +: hrmacs_pkg::FS_MULT_W];
  wire ddc_pullup_disable = link_line_and_fifo_control_ff[hrmacs_pkg::BIT_DDC_PULLUP_DIS];
  wire term_override = link_line_and_fifo_control_ff[hrmacs_pkg::BIT_TERM_OVERRIDE];
  wire term_manual_off = link_line_and_fifo_control_ff[hrmacs_pkg::BIT_TERM_MANUAL_OFF];
  wire fifo_underflow_autoreset = link_line_and_fifo_control_ff[hrmacs_pkg::BIT_FIFO_UF_AUTORESET];
  wire fifo_overflow_autoreset = link_line_and_fifo_control_ff[hrmacs_pkg::BIT_FIFO_OF_AUTORESET];
  wire ddc_lines_tristate = link_line_and_fifo_control_ff[hrmacs_pkg::BIT_DDC_TRISTATE];

  // Link mute state. A packet carrying both set and clear is treated as no change.
  logic link_mute_ff;
  wire gcp_set = GCP_VALID && GCP_SET_AVMUTE && !GCP_CLEAR_AVMUTE;
  wire gcp_clr = GCP_VALID && GCP_CLEAR_AVMUTE && !GCP_SET_AVMUTE;

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      link_mute_ff <= 1'b0;
    end else if (gcp_set) begin
      link_mute_ff <= 1'b1;
    end else if (gcp_clr) begin
      link_mute_ff <= 1'b0;
    end
  end

  wire nxt_av_mute = mute_override ? mute_sw_value : link_mute_ff;
  wire nxt_video_mute = nxt_av_mute && !video_mute_dis;
  wire nxt_audio_mute = nxt_av_mute && !audio_mute_dis;

  // Master clock controls. The divisor and ratio are given as plain numbers
  // so that the clock generator needs no decoding of its own.
  wire [3:0] nxt_mclk_divisor = {1'b0, mclk_div} + 4'h1;
  wire [3:0] fs_steps = {1'b0, master_clk_fs_multiple} + 4'h1;
  wire [hrmacs_pkg::FS_RATIO_W-1:0] nxt_fs_ratio =
    hrmacs_pkg::FS_RATIO_W'(fs_steps) * hrmacs_pkg::FS_RATIO_W'(hrmacs_pkg::FS_UNIT);

  // Clock termination: automatic mode disconnects it while no clock is seen.
  wire nxt_term_off = term_override ? term_manual_off : !clk_det_ff;

  // FIFO auto-reset request, high for one cycle after any cycle with an enabled underflow or overflow.
  wire nxt_fifo_reset = (AFIFO_UNDERFLOW && fifo_underflow_autoreset) ||
                        (AFIFO_OVERFLOW && fifo_overflow_autoreset);

  logic av_mute_ff;
  logic video_mute_ff;
  logic audio_mute_ff;
  logic pll_en_ff;
  logic [3:0] mclk_divisor_ff;
  logic [hrmacs_pkg::FS_RATIO_W-1:0] fs_ratio_ff;
  logic pullup_en_ff;
  logic ddc_oe_ff;
  logic term_off_ff;
  logic fifo_reset_ff;

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      av_mute_ff <= 1'b0;
      video_mute_ff <= 1'b0;
      audio_mute_ff <= 1'b0;
      pll_en_ff <= 1'b0;
      mclk_divisor_ff <= 4'h1;
      fs_ratio_ff <= hrmacs_pkg::FS_RATIO_W'(hrmacs_pkg::FS_UNIT);
      pullup_en_ff <= 1'b1;
      ddc_oe_ff <= 1'b1;
      term_off_ff <= 1'b1;
      fifo_reset_ff <= 1'b0;
    end else begin
      av_mute_ff <= nxt_av_mute;
      video_mute_ff <= nxt_video_mute;
      audio_mute_ff <= nxt_audio_mute;
      pll_en_ff <= pll_en;
      mclk_divisor_ff <= nxt_mclk_divisor;
      fs_ratio_ff <= nxt_fs_ratio;
      pullup_en_ff <= !ddc_pullup_disable;
      ddc_oe_ff <= !ddc_lines_tristate;
      term_off_ff <= nxt_term_off;
      fifo_reset_ff <= nxt_fifo_reset;
    end
  end

  assign AV_MUTE = av_mute_ff;
  assign VIDEO_MUTE = video_mute_ff;
  assign AUDIO_MUTE = audio_mute_ff;
  assign MCLK_PLL_EN = pll_en_ff;
  assign MCLK_DIVISOR = mclk_divisor_ff;
  assign MCLK_FS_RATIO = fs_ratio_ff;
  assign DDC_PULLUP_EN = pullup_en_ff;
  assign DDC_SDA_OE = ddc_oe_ff;
  assign DDC_SCL_OE = ddc_oe_ff;
  assign CLK_TERM_OFF = term_off_ff;
  assign AFIFO_RESET = fifo_reset_ff;

  // Packet-seen flags and stored clock regeneration values.
  logic [hrmacs_pkg::PKT_NUM-1:0] pkt_seen;
  logic [hrmacs_pkg::ACR_W-1:0] cts_val;
  logic [hrmacs_pkg::ACR_W-1:0] n_val;

  hrmacs_pkt_flags #(
    .NUM(hrmacs_pkg::PKT_NUM)
  ) u_pkt_flags (
    .clk(CLK_SYS),
    .rstn(RSTN),
    .pkt_valid(PKT_VALID),
    .pkt_type(PKT_TYPE),
    .clk_lost(clk_lost_ff),
    .seen_ff(pkt_seen)
  );

  hrmacs_acr_store #(
    .W(hrmacs_pkg::ACR_W)
  ) u_acr_store (
    .clk(CLK_SYS),
    .rstn(RSTN),
    .acr_valid(ACR_VALID),
    .acr_cts(ACR_CTS),
    .acr_n(ACR_N),
    .update_block(acr_update_block),
    .cts_ff(cts_val),
    .n_ff(n_val)
  );

  // Channel status capture. Fields are reported as received, except the top two accuracy and rate bits; reserved codes
  // are passed through so software can see a non-conforming source.
  logic [7:0] audio_status_flags_ff;
  logic [7:0] audio_category_ff;
  logic [7:0] audio_channel_source_ids_ff;
  logic [7:0] audio_accuracy_and_rate_ff;
  logic [3:0] word_len_ff;
  logic hdmi_mode_ff;
  // Clock accuracy and sampling rate occupy only the low six bits.
  localparam logic [7:0] acc_rate_keep_mask = 8'h3F;

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      audio_status_flags_ff <= hrmacs_pkg::RST_ZERO;
      audio_category_ff <= hrmacs_pkg::RST_ZERO;
      audio_channel_source_ids_ff <= hrmacs_pkg::RST_ZERO;
      audio_accuracy_and_rate_ff <= hrmacs_pkg::RST_ZERO;
      word_len_ff <= 4'h0;
      hdmi_mode_ff <= 1'b0;
    end else begin
      hdmi_mode_ff <= HDMI_MODE;
      if (CS_VALID) begin
        audio_status_flags_ff <= CS_STATUS;
        audio_category_ff <= CS_CATEGORY;
        audio_channel_source_ids_ff <= CS_CH_SRC;
        audio_accuracy_and_rate_ff <= CS_ACC_RATE & acc_rate_keep_mask;
        word_len_ff <= CS_WORD_LEN;
      end
    end
  end

  // Read multiplexer; unmapped offsets read as zero. The five time stamp and
  // N bytes are not latched together, so software reading them while a packet
  // lands may see a mix of old and new values.
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = hrmacs_pkg::RST_ZERO;
    case (REG_ADDR)
      hrmacs_pkg::OFS_TEST_CFG_B: rd_mux = test_config_b_ff;
      hrmacs_pkg::OFS_AV_MUTE_CTRL: rd_mux = av_mute_control_ff;
      hrmacs_pkg::OFS_MCLK_SETUP: rd_mux = audio_master_clock_setup_ff;
      hrmacs_pkg::OFS_LINK_FIFO_CTRL: rd_mux = link_line_and_fifo_control_ff;
      hrmacs_pkg::OFS_PKT_SEEN: rd_mux = {1'b0, pkt_seen};
      hrmacs_pkg::OFS_LINK_MODE: rd_mux = 8'(hdmi_mode_ff) << hrmacs_pkg::BIT_HDMI_MODE;
      hrmacs_pkg::OFS_AUDIO_STATUS: rd_mux = audio_status_flags_ff;
      hrmacs_pkg::OFS_AUDIO_CATEGORY: rd_mux = audio_category_ff;
      hrmacs_pkg::OFS_AUDIO_CH_SRC: rd_mux = audio_channel_source_ids_ff;
      hrmacs_pkg::OFS_AUDIO_ACC_RATE: rd_mux = audio_accuracy_and_rate_ff;
      hrmacs_pkg::OFS_AUDIO_WORD_LEN: rd_mux = {4'h0, word_len_ff};
      hrmacs_pkg::OFS_CTS_HI: rd_mux = cts_val[19:12];
      hrmacs_pkg::OFS_CTS_MID: rd_mux = cts_val[11:4];
      hrmacs_pkg::OFS_CTS_LO_N_HI: rd_mux = {cts_val[3:0], n_val[19:16]};
      hrmacs_pkg::OFS_N_MID: rd_mux = n_val[15:8];
      hrmacs_pkg::OFS_N_LO: rd_mux = n_val[7:0];
      default: rd_mux = hrmacs_pkg::RST_ZERO;
    endcase
  end

  // Read data stand only in the cycle after the strobe, zero otherwise.
  logic [7:0] rdata_ff;
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      rdata_ff <= hrmacs_pkg::RST_ZERO;
    end else begin
      rdata_ff <= REG_RD ? rd_mux : hrmacs_pkg::RST_ZERO;
    end
  end

  assign REG_RDATA = rdata_ff;
endmodule : hrmacs_regs
